// File: common/gwe_cfg.svh
// Register offsets, field positions, reset values of the write engine
`ifndef GWE_CFG_SVH
`define GWE_CFG_SVH
`define GWE_OFS_CTRL 8'h00
`define GWE_OFS_ADDR 8'h04
`define GWE_OFS_WINH 8'h08
`define GWE_OFS_WINV 8'h0C
`define GWE_OFS_MASK 8'h10
`define GWE_OFS_CMP 8'h14
`define GWE_OFS_DATA 8'h18
`define GWE_OFS_STAT 8'h1C
`define GWE_CTRL_FAST 0
`define GWE_CTRL_DIR 1
`define GWE_CTRL_AXIS 2
`define GWE_CTRL_LG_LO 3
`define GWE_CTRL_LG_HI 5
`define GWE_CTRL_BUS18 6
`define GWE_LG_REPLACE 3'h0
`define GWE_LG_CMP_NE 3'h6
`define GWE_LG_CMP_EQ 3'h7
`define GWE_RST_DIR 1'h1
`define GWE_RST_LEFT 8'h00
`define GWE_RST_RIGHT 8'hAF
`define GWE_RST_TOP 8'h00
`define GWE_RST_BOTTOM 8'hEF
`define GWE_GROUP_LAST 2'h3
`endif

// File: common/gwe_pkg.sv
// Types shared by the graphics RAM write engine
package gwe_pkg;
  typedef logic [17:0] gwe_word_t;
  typedef logic [15:0] gwe_addr_t;
  typedef logic [7:0] gwe_coord_t;
  typedef logic [2:0] gwe_logic_t;
endpackage : gwe_pkg

// File: rtl/gwe_addr_step.sv
// Next value of the address counter inside the window
`timescale 1ns/1ns
module gwe_addr_step
  import gwe_pkg::*;
(
  input wire gwe_pkg::gwe_addr_t cur, // Present counter
  input wire logic axis_vert, // 1 vertical stepping
  input wire logic dir_inc, // 1 increment
  input wire gwe_pkg::gwe_coord_t left, // Window left
  input wire gwe_pkg::gwe_coord_t right, // Window right
  input wire gwe_pkg::gwe_coord_t top, // Window top
  input wire gwe_pkg::gwe_coord_t bottom, // Window bottom
  output gwe_pkg::gwe_addr_t nxt // Counter after one write
);
  gwe_coord_t x;
  gwe_coord_t y;
  gwe_coord_t x_side;
  gwe_coord_t y_down;

  always_comb begin
    x = cur[7:0];
    y = cur[15:8];
    y_down = (y == bottom) ? top : y + 8'h01;
    if (dir_inc) begin
      x_side = (x == right) ? left : x + 8'h01;
    end else begin
      x_side = (x == left) ? right : x - 8'h01;
    end
    if (!axis_vert) begin
      // Edge of the line: opposite side of the next line
      if ((dir_inc && x == right) || (!dir_inc && x == left)) begin
        nxt = {y_down, x_side};
      end else begin
        nxt = {y, x_side};
      end
    end else begin
      // Plus 256 is one row down; bottom wraps to next column
      if (y == bottom) begin
        nxt = {top, x_side};
      end else begin
        nxt = {y + 8'h01, x};
      end
    end
  end
endmodule : gwe_addr_step

// File: rtl/gwe_word_proc.sv
// Expands a host word and decides whether a normal write is stored
`timescale 1ns/1ns
`include "gwe_cfg.svh"
module gwe_word_proc
  import gwe_pkg::*;
(
  input wire logic [31:0] host_data, // Raw bus data
  input wire logic bus18, // 1 word already 18 bits
  input wire logic cond_allowed, // 0 in fast write mode
  input wire gwe_pkg::gwe_logic_t lg_code, // Logic select code
  input wire gwe_pkg::gwe_word_t cmp_val, // Compare value
  output gwe_pkg::gwe_word_t word, // Pixel word to store
  output logic store_ok // Condition holds
);
  logic same;

  always_comb begin
    if (bus18) begin
      word = host_data[17:0];
    end else begin
      // Red and blue get their top bit repeated into the new LSB
      word = {host_data[15:11], host_data[15], host_data[10:5],
              host_data[4:0], host_data[4]};
    end
    same = (word == cmp_val);
    store_ok = 1'b1;
    // Fast mode never compares: every word goes to the stage
    if (cond_allowed) begin
      case (lg_code)
        `GWE_LG_CMP_NE: store_ok = !same;
        `GWE_LG_CMP_EQ: store_ok = same;
        default: store_ok = 1'b1;
      endcase
    end
  end
endmodule : gwe_word_proc

// File: rtl/gwe_engine.sv
// Graphics RAM write engine with APB register access
//
// Contract
// - No logic or compare in fast mode
// - Fast mode commits only full groups of four
// - Fast mode always writes; host clears before reads
// - Start dummies follow left bound low bits
// - End dummies follow right bound low bits
// - Writes confined to programmed window rectangle
// - Expand 16-bit words, keep 18-bit words
// - Mask bit one keeps stored RAM bit
// - Code 000 replaces, 110/111 conditional
// - Conditional store only when compare holds
// - Horizontal step by one, wrap lines
// - Vertical step by 256, wrap columns
// - Stage four words, commit while accepting more
`timescale 1ns/1ns
`include "gwe_cfg.svh"
module gwe_engine
  import gwe_pkg::*;
(
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  output logic ram_we, // RAM write pulse
  output gwe_pkg::gwe_addr_t ram_addr, // Group base address in fast mode, word address in normal mode
  output logic [3:0] ram_lane_en, // Per word enable
  output logic [71:0] ram_wdata, // Four words, lane 0 low
  output gwe_pkg::gwe_word_t ram_bit_mask // 1 keeps RAM bit
);
  ////////////////////////////////////////////////////////////////////
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic fast_write_mode_r, fast_write_mode_nxt;
  logic step_direction_low_bit_r, step_direction_low_bit_nxt;
  logic stepping_axis_select_r, stepping_axis_select_nxt;
  gwe_logic_t logic_select_code_r, logic_select_code_nxt;
  logic bus18_r, bus18_nxt;
  gwe_addr_t address_counter_r, address_counter_nxt;
  gwe_coord_t window_left_bound_r, window_left_bound_nxt;
  gwe_coord_t window_right_bound_r, window_right_bound_nxt;
  gwe_coord_t window_top_bound_r, window_top_bound_nxt;
  gwe_coord_t window_bottom_bound_r, window_bottom_bound_nxt;
  gwe_word_t write_bit_mask_r, write_bit_mask_nxt;
  gwe_word_t compare_value_r, compare_value_nxt;
  gwe_word_t stage_r [4];
  gwe_word_t stage_nxt [4];
  logic [1:0] stage_cnt_r, stage_cnt_nxt;
  logic ram_we_r, ram_we_nxt;
  gwe_addr_t ram_addr_r, ram_addr_nxt;
  logic [3:0] ram_lane_en_r, ram_lane_en_nxt;
  logic [71:0] ram_wdata_r, ram_wdata_nxt;
  gwe_word_t ram_bit_mask_r, ram_bit_mask_nxt;

  logic setup;
  logic access_wr;
  logic mapped;
  gwe_word_t word;
  logic store_ok;
  gwe_addr_t step_addr;
  gwe_coord_t eff_left;
  gwe_coord_t eff_right;
  logic eff_vert;
  logic [71:0] group_data;
  logic [3:0] group_en;
  logic [3:0] single_en;

  ////////////////////////////////////////////////////////////////////
  // In fast mode the counter walks whole aligned groups so the host's
  // dummy writes land on the padding positions around the window
  always_comb begin
    if (fast_write_mode_r) begin
      eff_left = {window_left_bound_r[7:2], 2'h0};
      eff_right = {window_right_bound_r[7:2], 2'h3};
    end else begin
      eff_left = window_left_bound_r;
      eff_right = window_right_bound_r;
    end
    // Fast mode supports horizontal stepping only
    eff_vert = stepping_axis_select_r & ~fast_write_mode_r;
  end

  gwe_addr_step u_step (
    .cur(address_counter_r),
    .axis_vert(eff_vert),
    .dir_inc(step_direction_low_bit_r),
    .left(eff_left),
    .right(eff_right),
    .top(window_top_bound_r),
    .bottom(window_bottom_bound_r),
    .nxt(step_addr)
  );

  gwe_word_proc u_word (
    .host_data(pwdata),
    .bus18(bus18_r),
    .cond_allowed(~fast_write_mode_r),
    .lg_code(logic_select_code_r),
    .cmp_val(compare_value_r),
    .word(word),
    .store_ok(store_ok)
  );

  ////////////////////////////////////////////////////////////////////
  // Group assembly: the arriving word fills its own lane directly
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      localparam logic [1:0] LANE = 2'(gi);
      logic [7:0] lane_x;
      assign lane_x = {address_counter_r[7:2], LANE};
      assign group_data[gi*18 +: 18] =
        (address_counter_r[1:0] == LANE) ? word : stage_r[gi];
      // Padding positions outside the window are dropped
      assign group_en[gi] = (lane_x >= window_left_bound_r) &&
                            (lane_x <= window_right_bound_r);
      assign single_en[gi] = (address_counter_r[1:0] == LANE);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    setup = psel & ~penable;
    access_wr = psel & penable & pready_r & pwrite & ~pslverr_r;
    case (paddr)
      `GWE_OFS_CTRL, `GWE_OFS_ADDR, `GWE_OFS_WINH, `GWE_OFS_WINV,
      `GWE_OFS_MASK, `GWE_OFS_CMP, `GWE_OFS_DATA,
      `GWE_OFS_STAT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase

    pready_nxt = setup;
    pslverr_nxt = setup & ~mapped;
    prdata_nxt = prdata_r;
    fast_write_mode_nxt = fast_write_mode_r;
    step_direction_low_bit_nxt = step_direction_low_bit_r;
    stepping_axis_select_nxt = stepping_axis_select_r;
    logic_select_code_nxt = logic_select_code_r;
    bus18_nxt = bus18_r;
    address_counter_nxt = address_counter_r;
    window_left_bound_nxt = window_left_bound_r;
    window_right_bound_nxt = window_right_bound_r;
    window_top_bound_nxt = window_top_bound_r;
    window_bottom_bound_nxt = window_bottom_bound_r;
    write_bit_mask_nxt = write_bit_mask_r;
    compare_value_nxt = compare_value_r;
    stage_nxt = stage_r;
    stage_cnt_nxt = stage_cnt_r;
    ram_we_nxt = 1'b0;
    ram_addr_nxt = ram_addr_r;
    ram_lane_en_nxt = ram_lane_en_r;
    ram_wdata_nxt = ram_wdata_r;
    ram_bit_mask_nxt = ram_bit_mask_r;

    // Read data only means something in a read access; a write access zeroes it, idle cycles hold it
    if (setup) begin
      prdata_nxt = 32'h0000_0000;
    end
    if (setup && !pwrite) begin
      case (paddr)
        `GWE_OFS_CTRL: prdata_nxt[6:0] = {bus18_r,
          logic_select_code_r, stepping_axis_select_r,
          step_direction_low_bit_r, fast_write_mode_r};
        `GWE_OFS_ADDR: prdata_nxt[15:0] = address_counter_r;
        `GWE_OFS_WINH: prdata_nxt[15:0] = {window_right_bound_r,
                                           window_left_bound_r};
        `GWE_OFS_WINV: prdata_nxt[15:0] = {window_bottom_bound_r,
                                           window_top_bound_r};
        `GWE_OFS_MASK: prdata_nxt[17:0] = write_bit_mask_r;
        `GWE_OFS_CMP: prdata_nxt[17:0] = compare_value_r;
        `GWE_OFS_STAT: prdata_nxt[2:0] = {fast_write_mode_r,
                                          stage_cnt_r};
        // RAM reads are not served by this engine
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end

    if (access_wr) begin
      case (paddr)
        `GWE_OFS_CTRL: begin
          fast_write_mode_nxt = pwdata[`GWE_CTRL_FAST];
          step_direction_low_bit_nxt = pwdata[`GWE_CTRL_DIR];
          stepping_axis_select_nxt = pwdata[`GWE_CTRL_AXIS];
          logic_select_code_nxt =
            pwdata[`GWE_CTRL_LG_HI:`GWE_CTRL_LG_LO];
          bus18_nxt = pwdata[`GWE_CTRL_BUS18];
          // A mode switch discards a partial group
          if (pwdata[`GWE_CTRL_FAST] != fast_write_mode_r) begin
            stage_cnt_nxt = 2'h0;
          end
        end
        `GWE_OFS_ADDR: begin
          address_counter_nxt = pwdata[15:0];
          stage_cnt_nxt = 2'h0;
        end
        `GWE_OFS_WINH: begin
          window_left_bound_nxt = pwdata[7:0];
          window_right_bound_nxt = pwdata[15:8];
        end
        `GWE_OFS_WINV: begin
          window_top_bound_nxt = pwdata[7:0];
          window_bottom_bound_nxt = pwdata[15:8];
        end
        `GWE_OFS_MASK: write_bit_mask_nxt = pwdata[17:0];
        `GWE_OFS_CMP: compare_value_nxt = pwdata[17:0];
        `GWE_OFS_DATA: begin
          address_counter_nxt = step_addr;
          if (fast_write_mode_r) begin
            // The first word after selection is always taken
            stage_nxt[address_counter_r[1:0]] = word;
            stage_cnt_nxt = stage_cnt_r + 2'h1;
            if (stage_cnt_r == `GWE_GROUP_LAST) begin
              // Output registers free the stage for the next group
              ram_we_nxt = 1'b1;
              ram_addr_nxt = {address_counter_r[15:2], 2'h0};
              ram_lane_en_nxt = group_en;
              ram_wdata_nxt = group_data;
              ram_bit_mask_nxt = write_bit_mask_r;
              stage_cnt_nxt = 2'h0;
            end
          end else if (store_ok) begin
            ram_we_nxt = 1'b1;
            ram_addr_nxt = address_counter_r;
            ram_lane_en_nxt = single_en;
            ram_wdata_nxt = {4{word}};
            ram_bit_mask_nxt = write_bit_mask_r;
          end
        end
        default: prdata_nxt = prdata_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      fast_write_mode_r <= 1'b0;
      step_direction_low_bit_r <= `GWE_RST_DIR;
      stepping_axis_select_r <= 1'b0;
      logic_select_code_r <= `GWE_LG_REPLACE;
      bus18_r <= 1'b0;
      address_counter_r <= 16'h0000;
      window_left_bound_r <= `GWE_RST_LEFT;
      window_right_bound_r <= `GWE_RST_RIGHT;
      window_top_bound_r <= `GWE_RST_TOP;
      window_bottom_bound_r <= `GWE_RST_BOTTOM;
      write_bit_mask_r <= 18'h00000;
      compare_value_r <= 18'h00000;
      for (int i = 0; i < 4; i++) begin
        stage_r[i] <= 18'h00000;
      end
      stage_cnt_r <= 2'h0;
      ram_we_r <= 1'b0;
      ram_addr_r <= 16'h0000;
      ram_lane_en_r <= 4'h0;
      ram_wdata_r <= 72'h0;
      ram_bit_mask_r <= 18'h00000;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      fast_write_mode_r <= fast_write_mode_nxt;
      step_direction_low_bit_r <= step_direction_low_bit_nxt;
      stepping_axis_select_r <= stepping_axis_select_nxt;
      logic_select_code_r <= logic_select_code_nxt;
      bus18_r <= bus18_nxt;
      address_counter_r <= address_counter_nxt;
      window_left_bound_r <= window_left_bound_nxt;
      window_right_bound_r <= window_right_bound_nxt;
      window_top_bound_r <= window_top_bound_nxt;
      window_bottom_bound_r <= window_bottom_bound_nxt;
      write_bit_mask_r <= write_bit_mask_nxt;
      compare_value_r <= compare_value_nxt;
      stage_r <= stage_nxt;
      stage_cnt_r <= stage_cnt_nxt;
      ram_we_r <= ram_we_nxt;
      ram_addr_r <= ram_addr_nxt;
      ram_lane_en_r <= ram_lane_en_nxt;
      ram_wdata_r <= ram_wdata_nxt;
      ram_bit_mask_r <= ram_bit_mask_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign ram_we = ram_we_r;
  assign ram_addr = ram_addr_r;
  assign ram_lane_en = ram_lane_en_r;
  assign ram_wdata = ram_wdata_r;
  assign ram_bit_mask = ram_bit_mask_r;
endmodule : gwe_engine

// File: bench/gwe_engine_assertions.sv
// Port-level checks of the write engine
`timescale 1ns/1ns
////////////////////////////////////////
module gwe_engine_chk
  import gwe_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic ram_we, // RAM write pulse
  input wire gwe_pkg::gwe_addr_t ram_addr, // RAM address
  input wire logic [3:0] ram_lane_en, // Lane enables
  input wire logic [71:0] ram_wdata, // Lane data
  input wire gwe_pkg::gwe_word_t ram_bit_mask // Keep mask
);
  logic data_acc;
  // Pixel word accepted at this edge
  assign data_acc = psel && penable && pready && pwrite && paddr == 8'h18;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_err_unmapped: assert property (pready && paddr > 8'h1C |-> pslverr)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property
    (pready && paddr <= 8'h1C && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  chk_err_rdzero: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  chk_we_single: assert property (ram_we |=> !ram_we)
    else $error("ram_we longer than one cycle");
  chk_we_cause: assert property
    (ram_we |-> $past(data_acc) || $past(data_acc, 2))
    else $error("ram_we without a pixel write");
  chk_ram_hold: assert property (!ram_we |-> $stable(ram_addr) &&
    $stable(ram_lane_en) && $stable(ram_wdata) && $stable(ram_bit_mask))
    else $error("RAM outputs moved without write");
endmodule : gwe_engine_chk
bind gwe_engine gwe_engine_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ram_we(ram_we), .ram_addr(ram_addr), .ram_lane_en(ram_lane_en),
  .ram_wdata(ram_wdata), .ram_bit_mask(ram_bit_mask));

// File: bench/gwe_host.sv
// Host microcomputer model: APB master
`timescale 1ns/1ns
////////////////////////////////////////
module gwe_host (
  input wire logic pclk, // Clock
  output logic psel, // Select
  output logic penable, // Enable
  output logic pwrite, // Direction
  output logic [7:0] paddr, // Address
  output logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr // Error
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err,
    output logic ok);
    ok = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge pclk);
      ok = pready;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines no longer show the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : gwe_host

// File: bench/testbench.sv
// Self-checking bench for the graphics RAM write engine
`timescale 1ns/1ns
////////////////////////////////////////
module testbench;
  import gwe_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, ram_we, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  gwe_addr_t ram_addr, we_addr;
  logic [3:0] ram_lane_en, we_lanes;
  logic [71:0] ram_wdata, we_data;
  gwe_word_t ram_bit_mask, we_mask;
  int failures = 0;
  int n_checks = 0;
  int n_we = 0;
  always #20 pclk = ~pclk;
  gwe_engine DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_lane_en(ram_lane_en), .ram_wdata(ram_wdata),
    .ram_bit_mask(ram_bit_mask));
  gwe_host host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  // Sees the pulse of the cycle before the edge, never a half update
  always @(posedge pclk) begin
    if (ram_we === 1'b1) begin
      n_we++;
      we_addr = ram_addr;
      we_lanes = ram_lane_en;
      we_data = ram_wdata;
      we_mask = ram_bit_mask;
    end
  end
  ////////////////////////////////////////
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  task automatic chk_val(string nm, logic [71:0] exp, logic [71:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk_val
  task automatic chk_cnt(string nm, int exp, int got);
    n_checks++;
    if (got != exp) begin
      failures++;
      $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_cnt
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    logic ok;
    host.xfer(w, a, d, rdat, rerr, ok);
    if (!ok) begin
      failures++;
      $display("MISMATCH pready expected 1 seen 0");
      results();
    end
  endtask : bus
  task automatic chk_rd(logic [7:0] a, logic [31:0] exp, string nm);
    bus(1'b0, a, 32'h0);
    chk_val(nm, exp, rdat);
  endtask : chk_rd
  // Commit shows one cycle after the access edge; margin of two more
  task automatic settle();
    repeat (3) @(posedge pclk);
    #1;
  endtask : settle
  ////////////////////////////////////////
  task automatic t_regs();
    chk_rd(8'h00, 32'h2, "ctrl_reset");
    chk_rd(8'h04, 32'h0, "addr_reset");
    chk_rd(8'h08, 32'hAF00, "winh_reset");
    chk_rd(8'h0C, 32'hEF00, "winv_reset");
    chk_rd(8'h10, 32'h0, "mask_reset");
    chk_rd(8'h14, 32'h0, "cmp_reset");
    chk_rd(8'h1C, 32'h0, "stat_reset");
    bus(1'b1, 8'h10, 32'hFFFFFFFF);
    chk_rd(8'h10, 32'h3FFFF, "mask_width");
    bus(1'b1, 8'h24, 32'h1);
    chk_val("wr_err", 1'h1, rerr);
    chk_rd(8'h24, 32'h0, "unmapped_rd");
    chk_val("rd_err", 1'h1, rerr);
    $display("test t_regs done");
  endtask : t_regs
  task automatic t_normal();
    int n0;
    bus(1'b1, 8'h00, 32'h2);
    bus(1'b1, 8'h10, 32'hFFF);
    bus(1'b1, 8'h04, 32'h5);
    n0 = n_we;
    bus(1'b1, 8'h18, 32'h8410);
    settle();
    chk_cnt("commits", 1, n_we - n0);
    chk_val("addr", 16'h5, we_addr);
    chk_val("lanes1", 4'h2, we_lanes);
    chk_val("word", 18'h21821, we_data[17:0]);
    chk_val("mask", 18'hFFF, we_mask);
    chk_rd(8'h04, 32'h6, "counter");
    $display("test t_normal done");
  endtask : t_normal
  task automatic t_step();
    logic [31:0] cs[5][5] = '{'{32'h40, 32'h704, 32'hEF00, 32'h4, 32'h107},
      '{32'h42, 32'h704, 32'hEF00, 32'h7, 32'h104},
      '{32'h46, 32'hAF00, 32'h200, 32'h103, 32'h203},
      '{32'h46, 32'hAF00, 32'h200, 32'h203, 32'h4},
      '{32'h44, 32'hAF00, 32'h200, 32'h203, 32'h2}};
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 8'h00, cs[i][0]);
      bus(1'b1, 8'h08, cs[i][1]);
      bus(1'b1, 8'h0C, cs[i][2]);
      bus(1'b1, 8'h04, cs[i][3]);
      bus(1'b1, 8'h18, 32'h2AAAA + i);
      settle();
      chk_val("word18", 18'h2AAAA + i, we_data[17:0]);
      chk_rd(8'h04, cs[i][4], "step");
    end
    $display("test t_step done");
  endtask : t_step
  task automatic t_cond();
    logic [31:0] cs[5][3] = '{'{32'h72, 32'h15555, 32'h0},
      '{32'h72, 32'h15554, 32'h1}, '{32'h7A, 32'h15555, 32'h1},
      '{32'h7A, 32'h15554, 32'h0}, '{32'h42, 32'h15555, 32'h1}};
    int n0;
    bus(1'b1, 8'h08, 32'hAF00);
    bus(1'b1, 8'h0C, 32'hEF00);
    bus(1'b1, 8'h10, 32'h3);
    bus(1'b1, 8'h14, 32'h15555);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 8'h00, cs[i][0]);
      bus(1'b1, 8'h04, 32'h10);
      n0 = n_we;
      bus(1'b1, 8'h18, cs[i][1]);
      settle();
      chk_cnt("cond", int'(cs[i][2]), n_we - n0);
      if (cs[i][2] == 32'h1) chk_val("cond_mask", 18'h3, we_mask);
    end
    $display("test t_cond done");
  endtask : t_cond
  task automatic t_fast();
    int n0;
    bus(1'b1, 8'h00, 32'h73);
    bus(1'b1, 8'h08, 32'h601);
    bus(1'b1, 8'h10, 32'hF);
    bus(1'b1, 8'h14, 32'h3);
    bus(1'b1, 8'h04, 32'h0);
    for (int g = 0; g < 2; g++) begin
      n0 = n_we;
      for (int k = 1; k <= 3; k++) bus(1'b1, 8'h18, 32'(4 * g + k));
      settle();
      chk_cnt("staged", 0, n_we - n0);
      bus(1'b1, 8'h18, 32'(4 * g + 4));
      settle();
      chk_cnt("group", 1, n_we - n0);
      chk_val("base", 16'(4 * g), we_addr);
      chk_val("lanes", (g == 0) ? 4'hE : 4'h7, we_lanes);
      chk_val("data", {18'(4 * g + 4), 18'(4 * g + 3), 18'(4 * g + 2),
        18'(4 * g + 1)}, we_data);
      chk_val("fmask", 18'hF, we_mask);
    end
    chk_rd(8'h04, 32'h100, "fast_wrap");
    for (int k = 0; k < 3; k++) bus(1'b1, 8'h18, 32'h9);
    chk_rd(8'h1C, 32'h7, "stat");
    n0 = n_we;
    bus(1'b1, 8'h04, 32'h100);
    bus(1'b1, 8'h18, 32'h9);
    settle();
    chk_cnt("partial", 0, n_we - n0);
    chk_rd(8'h1C, 32'h5, "stat_drop");
    bus(1'b1, 8'h00, 32'h42);
    chk_rd(8'h1C, 32'h0, "stat_mode");
    $display("test t_fast done");
  endtask : t_fast
  // Fast mode walking downwards: group starts at low bits 11
  task automatic t_fast_dec();
    int n0;
    bus(1'b1, 8'h00, 32'h41);
    bus(1'b1, 8'h08, 32'hAF00);
    bus(1'b1, 8'h04, 32'h3);
    n0 = n_we;
    for (int k = 1; k <= 4; k++) bus(1'b1, 8'h18, 32'(k));
    settle();
    chk_cnt("dec_group", 1, n_we - n0);
    chk_val("dec_base", 16'h0, we_addr);
    chk_val("dec_lanes", 4'hF, we_lanes);
    chk_val("dec_data", {18'h1, 18'h2, 18'h3, 18'h4}, we_data);
    chk_rd(8'h04, 32'h1AF, "dec_wrap");
    $display("test t_fast_dec done");
  endtask : t_fast_dec
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_normal();
    t_step();
    t_cond();
    t_fast();
    t_fast_dec();
    results();
  end
endmodule : testbench
